// [verilog/qsr_pkg.sv]
// package for the questionable status register group
package qsr_pkg;

  localparam int QSR_WIDTH = 16;

  // event bit positions
  localparam int QSR_BIT_VOLT_UNREG = 0;
  localparam int QSR_BIT_CURR_UNREG = 1;
  localparam int QSR_BIT_FAN_FAULT = 4;
  localparam int QSR_BIT_OVP_TRIP = 9;
  localparam int QSR_BIT_OCP_TRIP = 10;

  // summary position in the status byte
  localparam int QSR_SB_QUES_BIT = 3;

  // implemented bits; all other event positions read zero, the enable mask is stored unmasked
  localparam logic [15:0] QSR_IMPL_MASK = 16'h0613;

  // reset values
  localparam logic [15:0] QSR_EVENT_RST = 16'h0000;
  localparam logic [15:0] QSR_ENABLE_RST = 16'h0000;

  // condition inputs from the supply's analog monitors
  typedef struct packed {
    logic volt_unreg;
    logic curr_unreg;
    logic fan_fault;
    logic ovp_trip;
    logic ocp_trip;
  } qsr_cond_type;

  // command strobes from the remote command parser
  typedef struct packed {
    logic event_rd;
    logic enable_wr;
    logic enable_rd;
    logic clear_status;
    logic reset_cmd;
    logic dev_clear;
  } qsr_cmd_type;

endpackage : qsr_pkg

// [verilog/qsr_status.sv]
// questionable status event and enable registers with summary bit
// Functional notes
// - event bits latch on condition and hold until explicitly cleared
// - event read and clear-status both clear all event bits
// - reset command and device clear leave event bits untouched
// - event read returns binary-weighted value of set bits
// - summary is OR of event bits gated by enable mask
// - enable mask readable and writable; read leaves it unchanged
// - clear-status does not alter the enable mask
// - bit 0 sets when output voltage loses regulation
// - bit 1 sets when output current loses regulation
// - bit 4 sets on fan fault, overtemperature
// - bit 9 sets on overvoltage protection trip
// - bit 10 sets on overcurrent protection trip
// - summary drives status byte bit 3
// - writing zero to the enable mask clears all enables
`timescale 1ns/1ps
`default_nettype none
module qsr_status
  import qsr_pkg::*;
(
  // clock and reset
  input wire logic clk,
  input wire logic nrst,
  // asynchronous condition pins
  input wire qsr_cond_type cond,
  // command strobes, one cycle each
  input wire qsr_cmd_type cmd,
  input wire logic [QSR_WIDTH-1:0] enable_wdata,
  // read data
  output logic [QSR_WIDTH-1:0] event_rdata,
  output logic [QSR_WIDTH-1:0] enable_rdata,
  // summary into the status byte
  output logic [7:0] status_byte_ques,
  output logic ques_summary
);

  localparam int NCOND = 5;

  logic [NCOND-1:0] cond_raw;
  logic [NCOND-1:0] s1_r, s2_r, s3_r;
  logic [NCOND-1:0] s1_nxt, s2_nxt, s3_nxt;
  logic [QSR_WIDTH-1:0] event_r, event_nxt;
  logic [QSR_WIDTH-1:0] enable_r, enable_nxt;
  logic [QSR_WIDTH-1:0] set_vec;
  logic [QSR_WIDTH-1:0] ev_rdata_r, ev_rdata_nxt;
  logic [QSR_WIDTH-1:0] en_rdata_r, en_rdata_nxt;
  logic summary_r, summary_nxt;

  assign cond_raw = {cond.ocp_trip, cond.ovp_trip, cond.fan_fault,
                     cond.curr_unreg, cond.volt_unreg};

  // three-stage synchroniser; stage 1 feeds only stage 2
  always_comb begin
    s1_nxt = cond_raw;
    s2_nxt = s1_r;
    s3_nxt = s2_r;
  end

  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      s1_r <= '0;
      s2_r <= '0;
      s3_r <= '0;
    end else begin
      s1_r <= s1_nxt;
      s2_r <= s2_nxt;
      s3_r <= s3_nxt;
    end
  end

  // a condition counts once stages two and three agree high;
  // level sampling so a held condition re-latches after a clear
  always_comb begin
    set_vec = '0;
    set_vec[QSR_BIT_VOLT_UNREG] = s2_r[0] & s3_r[0];
    set_vec[QSR_BIT_CURR_UNREG] = s2_r[1] & s3_r[1];
    set_vec[QSR_BIT_FAN_FAULT] = s2_r[2] & s3_r[2];
    set_vec[QSR_BIT_OVP_TRIP] = s2_r[3] & s3_r[3];
    set_vec[QSR_BIT_OCP_TRIP] = s2_r[4] & s3_r[4];
  end

  always_comb begin
    event_nxt = event_r;
    // read or clear-status empties the register
    if (cmd.event_rd || cmd.clear_status) begin
      event_nxt = '0;
    end
    // reset_cmd and dev_clear deliberately have no effect here
    // latch, set wins over a same-cycle clear
    event_nxt = (event_nxt | set_vec) & QSR_IMPL_MASK;
  end

  always_comb begin
    enable_nxt = enable_r;
    // write stores the weighted value, zero clears all
    if (cmd.enable_wr) begin
      enable_nxt = enable_wdata;
    end
  end

  always_comb begin
    ev_rdata_nxt = ev_rdata_r;
    en_rdata_nxt = en_rdata_r;
    if (cmd.event_rd) begin
      ev_rdata_nxt = event_r;
    end
    // mask read has no side effect
    if (cmd.enable_rd) begin
      en_rdata_nxt = enable_r;
    end
    summary_nxt = |(event_nxt & enable_nxt);
  end

  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      event_r <= QSR_EVENT_RST;
      enable_r <= QSR_ENABLE_RST;
      ev_rdata_r <= '0;
      en_rdata_r <= '0;
      summary_r <= 1'b0;
    end else begin
      event_r <= event_nxt;
      enable_r <= enable_nxt;
      ev_rdata_r <= ev_rdata_nxt;
      en_rdata_r <= en_rdata_nxt;
      summary_r <= summary_nxt;
    end
  end

  assign event_rdata = ev_rdata_r;
  assign enable_rdata = en_rdata_r;
  assign ques_summary = summary_r;

  // summary into status byte bit 3
  always_comb begin
    status_byte_ques = 8'h00;
    status_byte_ques[QSR_SB_QUES_BIT] = summary_r;
  end

endmodule : qsr_status
`default_nettype wire

// [tb/qsr_status_monitor.sv]
// assertion checker for the questionable status group
`timescale 1ns/1ps
`default_nettype none
module qsr_status_monitor
  import qsr_pkg::*;
(
  input wire logic clk,
  input wire logic nrst,
  input wire qsr_cond_type cond,
  input wire qsr_cmd_type cmd,
  input wire logic [15:0] enable_wdata,
  input wire logic [15:0] event_rdata,
  input wire logic [15:0] enable_rdata,
  input wire logic [7:0] status_byte_ques,
  input wire logic ques_summary
);
  default clocking @(posedge clk); endclocking
  default disable iff (!nrst);
  chk_sb_place: assert property (status_byte_ques == {4'h0, ques_summary, 3'h0})
    else $error("bad status byte");
  chk_unused_zero: assert property ((event_rdata & ~QSR_IMPL_MASK) == 16'h0)
    else $error("unused bit set");
  chk_mask_write: assert property (cmd.enable_wr ##1 !cmd.enable_wr ##1
    cmd.enable_rd && !cmd.enable_wr |=> enable_rdata == $past(enable_wdata, 3))
    else $error("mask readback");
  chk_read_holds: assert property (!cmd.event_rd |=> $stable(event_rdata))
    else $error("read data moved");
  chk_read_clears: assert property ((cond == 0)[*4] ##1 cmd.event_rd ##2
    cmd.event_rd |=> event_rdata == 16'h0)
    else $error("read did not clear");
  chk_summary_hold: assert property (ques_summary && !cmd.event_rd &&
    !cmd.clear_status && !cmd.enable_wr |=> ques_summary)
    else $error("summary dropped");
  chk_rise_cause: assert property ($rose(ques_summary) |->
    $past(cmd.enable_wr) || $past(cond, 4) != 0)
    else $error("summary without cause");
  chk_mask_zero: assert property (cmd.enable_wr && enable_wdata == 0 |=> !ques_summary)
    else $error("summary with zero mask");
endmodule : qsr_status_monitor
bind qsr_status qsr_status_monitor mon (.clk, .nrst, .cond, .cmd, .enable_wdata,
  .event_rdata, .enable_rdata, .status_byte_ques, .ques_summary);
`default_nettype wire

// [tb/test_qsr_status.sv]
// self-checking bench for the questionable status group
`timescale 1ns/1ps
`default_nettype none
module test_qsr_status
  import qsr_pkg::*;
;
  logic clk = 0;
  logic nrst = 0;
  qsr_cond_type cond = '0;
  qsr_cmd_type cmd = '0;
  logic [15:0] wd = '0;
  logic [15:0] ev;
  logic [15:0] en;
  logic [7:0] sb;
  logic qs;
  int miscompares = 0;
  int checked = 0;
  // condition, mask, expected event
  logic [36:0] rows [6] = '{{5'h10, 16'h0001, 16'h0001}, {5'h08, 16'hFFFF, 16'h0002},
    {5'h04, 16'h0010, 16'h0010}, {5'h02, 16'h0200, 16'h0200},
    {5'h01, 16'h0400, 16'h0400}, {5'h01, 16'h0200, 16'h0400}};
  always #50 clk = ~clk;
  qsr_status uut (.clk(clk), .nrst(nrst), .cond(cond), .cmd(cmd), .enable_wdata(wd),
    .event_rdata(ev), .enable_rdata(en), .status_byte_ques(sb), .ques_summary(qs));
  task automatic chk(string n, logic [15:0] s, logic [15:0] e);
    checked++;
    if (s !== e) begin
      miscompares++;
      $display("wrong value %s exp %h got %h", n, e, s);
    end
  endtask : chk
  task automatic pulse(qsr_cmd_type c, logic [15:0] d);
    @(negedge clk);
    cmd = c;
    wd = d;
    @(negedge clk);
    cmd = '0;
  endtask : pulse
  task automatic wrap_up;
    $display("checked %0d miscompares %0d", checked, miscompares);
    if (miscompares == 0 && checked > 0) $display("== PASSED ==");
    else $display("== FAILED ==");
    $finish;
  endtask : wrap_up
  initial begin
    repeat (5) @(negedge clk);
    nrst = 1;
    pulse(6'h28, '0);
    chk("event", ev, QSR_EVENT_RST);
    chk("enable", en, QSR_ENABLE_RST);
    $display("reset test done");
    foreach (rows[i]) begin
      pulse(6'h10, rows[i][31:16]);
      // hold two cycles: the synchroniser needs stages two and three to agree
      cond = rows[i][36:32];
      repeat (2) @(negedge clk);
      cond = '0;
      repeat (5) @(negedge clk);
      chk("summary", {15'h0, qs}, {15'h0, |(rows[i][15:0] & rows[i][31:16])});
      pulse(6'h20, '0);
      chk("event", ev, rows[i][15:0]);
      pulse(6'h20, '0);
      chk("event", ev, 16'h0);
      $display("row %0d done", i);
    end
    // clear while the synchronised conditions are still high: the new event must survive
    pulse(6'h10, 16'hFFFF);
    cond = '1;
    repeat (4) @(negedge clk);
    // drop the pins so the clear lands on the last edge that still sets
    cond = '0;
    pulse(6'h04, '0);
    repeat (5) @(negedge clk);
    pulse(6'h03, '0);
    chk("summary", {15'h0, qs}, 16'h1);
    pulse(6'h28, '0);
    chk("event", ev, QSR_IMPL_MASK);
    chk("enable", en, 16'hFFFF);
    pulse(6'h10, '0);
    pulse(6'h08, '0);
    chk("enable", en, 16'h0);
    $display("awkward tests done");
    wrap_up();
  end
  // about 106 cycles expected, so twenty microseconds is ample margin
  initial begin
    #20000;
    miscompares++;
    wrap_up();
  end
endmodule : test_qsr_status
`default_nettype wire
